// [rtl/cim_id_filter.sv]
// identifier tag and mask bytes of all message objects, sfr access and acceptance compare
// assumes page select, format flags and mask byte 4 come from neighbouring logic on ref_clk_i

`timescale 1ns/1ps

module cim_id_filter
  import cim_pkg::*;
(
  // clock and reset
  input  wire logic                              ref_clk_i,
  input  wire logic                              reset_n_i,
  // sfr port
  input  wire cim_sfr_req_t                      sfr_req_i,
  input  wire logic [CIM_OBJ_W-1:0]              obj_sel_i,
  output      logic [7:0]                        sfr_rdata_o,
  output      logic                              sfr_hit_o,
  // per object configuration held elsewhere
  input  wire logic [CIM_NUM_OBJ-1:0]            ext_fmt_i,
  input  wire logic [CIM_NUM_OBJ-1:0][7:0]       mask_byte4_i,
  // reception filter
  input  wire logic                              rx_valid_i,
  input  wire cim_frame_t                        rx_frame_i,
  output      logic [CIM_NUM_OBJ-1:0]            rx_hit_o,
  output      logic                              rx_done_o,
  // transmission tag
  input  wire logic                              tx_req_i,
  input  wire logic [CIM_OBJ_W-1:0]              tx_obj_i,
  output      cim_frame_t                        tx_frame_o,
  output      logic                              tx_valid_o
);

  // ****************************************
  // storage, no reset
  // ****************************************
  logic [7:0]             tag_q   [CIM_NUM_OBJ][4];
  logic [7:0]             mask_q  [CIM_NUM_OBJ][3];
  logic                   sel_ok;
  logic [CIM_OBJ_W-1:0]   sel_idx;

  assign sel_ok  = (obj_sel_i < CIM_OBJ_W'(CIM_NUM_OBJ));
  assign sel_idx = sel_ok ? obj_sel_i : '0;

  // bytes keep whatever was last written; unwritten bytes stay undefined
  always_ff @(posedge ref_clk_i) begin // R14
    if (sfr_req_i.wr && sel_ok) begin
      case (sfr_req_i.addr)
        CIM_ADDR_IDT1: tag_q[sel_idx][0]  <= sfr_req_i.wdata;
        CIM_ADDR_IDT2: tag_q[sel_idx][1]  <= sfr_req_i.wdata;
        CIM_ADDR_IDT3: tag_q[sel_idx][2]  <= sfr_req_i.wdata;
        CIM_ADDR_IDT4: tag_q[sel_idx][3]  <= sfr_req_i.wdata;
        CIM_ADDR_IDM1: mask_q[sel_idx][0] <= sfr_req_i.wdata;
        CIM_ADDR_IDM2: mask_q[sel_idx][1] <= sfr_req_i.wdata;
        CIM_ADDR_IDM3: mask_q[sel_idx][2] <= sfr_req_i.wdata;
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // per object layout decode
  // ****************************************
  cim_frame_t             obj_frame [CIM_NUM_OBJ];
  logic [CIM_ID_W-1:0]    obj_msk   [CIM_NUM_OBJ];
  logic [CIM_NUM_OBJ-1:0] match;

  for (genvar i = 0; i < CIM_NUM_OBJ; i++) begin : g_obj
    logic [CIM_ID_W-1:0] id_ext;
    logic [CIM_ID_W-1:0] id_std;
    logic [CIM_ID_W-1:0] msk_ext;
    logic [CIM_ID_W-1:0] msk_std;
    logic                msk_rtr;
    logic                msk_ide;

    assign id_ext  = {tag_q[i][0], tag_q[i][1], tag_q[i][2],
                      tag_q[i][3][7:CIM_B4_EXT_LSB]}; // R5 R6 R7 R8
    assign id_std  = {{18{1'b0}}, tag_q[i][0],
                      tag_q[i][1][7:CIM_B2_STD_LSB]}; // R1 R2
    assign msk_ext = {mask_q[i][0], mask_q[i][1], mask_q[i][2],
                      mask_byte4_i[i][7:CIM_B4_EXT_LSB]};
    assign msk_std = {{18{1'b0}}, mask_q[i][0],
                      mask_q[i][1][7:CIM_B2_STD_LSB]}; // R9 R10
    assign msk_rtr = mask_byte4_i[i][CIM_B4_RTR_POS];
    assign msk_ide = mask_byte4_i[i][CIM_B4_IDE_POS];

    // format flag picks the layout
    assign obj_frame[i] = ext_fmt_i[i] ?
      {id_ext, tag_q[i][3][CIM_B4_RTR_POS], 1'b1, tag_q[i][3][CIM_B4_RB1_POS],
       tag_q[i][3][CIM_B4_RB0_POS]} :
      {id_std, tag_q[i][3][CIM_B4_RTR_POS], 1'b0, 1'b0,
       tag_q[i][3][CIM_B4_RB0_POS]}; // R15 R4 R8
    assign obj_msk[i] = ext_fmt_i[i] ? msk_ext : msk_std; // R15

    // masked compare: a zero mask bit forces the bit true
    assign match[i] = ~|((rx_frame_i.id ^ obj_frame[i].id) & obj_msk[i])
                    & ~((rx_frame_i.rtr ^ obj_frame[i].rtr) & msk_rtr)
                    & ~((rx_frame_i.extended_format_select ^ obj_frame[i].extended_format_select) & msk_ide); // R12 R17
  end

  // ****************************************
  // sfr read
  // ****************************************
  logic [7:0] rd_data;
  logic       rd_map;
  logic       sel_ext;

  assign sel_ext = ext_fmt_i[sel_idx];

  always_comb begin
    rd_data = CIM_RDATA_RST;
    rd_map  = 1'b1;
    case (sfr_req_i.addr)
      CIM_ADDR_IDT1: rd_data = tag_q[sel_idx][0]; // R1 R5
      CIM_ADDR_IDT2: rd_data = tag_q[sel_idx][1] &
                               (sel_ext ? CIM_FULL_RMASK : CIM_STD_B2_RMASK); // R2 R6
      CIM_ADDR_IDT3: rd_data = tag_q[sel_idx][2] &
                               (sel_ext ? CIM_FULL_RMASK : CIM_STD_B3_RMASK); // R3 R7
      CIM_ADDR_IDT4: rd_data = tag_q[sel_idx][3] &
                               (sel_ext ? CIM_FULL_RMASK : CIM_STD_B4_RMASK); // R4 R8
      CIM_ADDR_IDM1: rd_data = mask_q[sel_idx][0]; // R9
      CIM_ADDR_IDM2: rd_data = mask_q[sel_idx][1] &
                               (sel_ext ? CIM_FULL_RMASK : CIM_STD_B2_RMASK); // R10
      CIM_ADDR_IDM3: rd_data = mask_q[sel_idx][2] &
                               (sel_ext ? CIM_FULL_RMASK : CIM_STD_B3_RMASK); // R11
      default: begin
        rd_map = 1'b0;
      end
    endcase
  end

  // read data stands until the next accepted read
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sfr_rdata_o <= CIM_RDATA_RST;
      sfr_hit_o   <= 1'b0;
    end else begin
      sfr_hit_o <= sfr_req_i.rd && rd_map && sel_ok;
      if (sfr_req_i.rd && rd_map && sel_ok) begin
        sfr_rdata_o <= rd_data;
      end
    end
  end

  // ****************************************
  // reception filter
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_hit_o  <= '0;
      rx_done_o <= 1'b0;
    end else begin
      rx_done_o <= rx_valid_i;
      if (rx_valid_i) begin
        rx_hit_o <= match; // R17
      end
    end
  end

  // ****************************************
  // transmission tag, unmasked
  // ****************************************
  logic       tx_ok;
  cim_frame_t tx_sel_frame;

  assign tx_ok        = tx_req_i && (tx_obj_i < CIM_OBJ_W'(CIM_NUM_OBJ));
  assign tx_sel_frame = obj_frame[tx_ok ? tx_obj_i : '0];

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_frame_o <= '0;
      tx_valid_o <= 1'b0;
    end else begin
      tx_valid_o <= tx_ok;
      if (tx_ok) begin
        tx_frame_o <= tx_sel_frame; // R16
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_wr(logic [7:0] a);
    sfr_req_i.wr && sel_ok && sfr_req_i.addr == a;
  endsequence

  sequence s_rd_same(logic [7:0] a);
    sfr_req_i.rd && !sfr_req_i.wr && sfr_req_i.addr == a
      && obj_sel_i == $past(obj_sel_i) && ext_fmt_i == $past(ext_fmt_i);
  endsequence

  a_tag_b1_readback: assert property ( // R1
    s_wr(CIM_ADDR_IDT1) ##1 s_rd_same(CIM_ADDR_IDT1)
      |=> sfr_hit_o && sfr_rdata_o == $past(sfr_req_i.wdata, 2))
    else $error("tag byte 1 read differs from last write");

  a_ext_b4_readback: assert property ( // R8
    s_wr(CIM_ADDR_IDT4) ##1 (s_rd_same(CIM_ADDR_IDT4) && sel_ext)
      |=> sfr_rdata_o == $past(sfr_req_i.wdata, 2))
    else $error("extended tag byte 4 lost bits");

  a_ext_b2_readback: assert property ( // R6
    s_wr(CIM_ADDR_IDT2) ##1 (s_rd_same(CIM_ADDR_IDT2) && sel_ext)
      |=> sfr_rdata_o == $past(sfr_req_i.wdata, 2))
    else $error("extended tag byte 2 lost bits");

  a_std_b2_layout: assert property ( // R2
    sfr_req_i.rd && sel_ok && !sel_ext && sfr_req_i.addr == CIM_ADDR_IDT2
      |=> sfr_hit_o && sfr_rdata_o[4:0] == 5'h00)
    else $error("standard tag byte 2 shows reserved bits");

  a_std_b3_empty: assert property ( // R3
    sfr_req_i.rd && sel_ok && !sel_ext && sfr_req_i.addr == CIM_ADDR_IDT3
      |=> sfr_rdata_o == 8'h00)
    else $error("standard tag byte 3 not empty");

  a_std_b4_layout: assert property ( // R4
    sfr_req_i.rd && sel_ok && !sel_ext && sfr_req_i.addr == CIM_ADDR_IDT4
      |=> sfr_rdata_o[7:3] == 5'h00 && !sfr_rdata_o[1])
    else $error("standard tag byte 4 shows reserved bits");

  a_std_mask_b2: assert property ( // R10
    sfr_req_i.rd && sel_ok && !sel_ext && sfr_req_i.addr == CIM_ADDR_IDM2
      |=> sfr_rdata_o[4:0] == 5'h00)
    else $error("standard mask byte 2 shows reserved bits");

  a_std_mask_b3: assert property ( // R11
    sfr_req_i.rd && sel_ok && !sel_ext && sfr_req_i.addr == CIM_ADDR_IDM3
      |=> sfr_rdata_o == 8'h00)
    else $error("standard mask byte 3 not empty");

  a_mask_b1_readback: assert property ( // R9
    s_wr(CIM_ADDR_IDM1) ##1 s_rd_same(CIM_ADDR_IDM1)
      |=> sfr_rdata_o == $past(sfr_req_i.wdata, 2))
    else $error("mask byte 1 read differs from last write");

  a_mask_zero_hit: assert property ( // R12
    rx_valid_i && obj_msk[0] == '0 && mask_byte4_i[0][CIM_B4_RTR_POS] == 1'b0
      && mask_byte4_i[0][CIM_B4_IDE_POS] == 1'b0
      |=> rx_done_o && rx_hit_o[0])
    else $error("fully masked object did not hit");

  a_equal_tag_hit: assert property ( // R17
    rx_valid_i && rx_frame_i.id == obj_frame[0].id && rx_frame_i.rtr == obj_frame[0].rtr
      && rx_frame_i.extended_format_select == obj_frame[0].extended_format_select
      |=> rx_hit_o[0] ##1 ($past(rx_valid_i) || rx_hit_o[0]))
    else $error("equal frame did not hit object 0");

  a_tx_unmasked_tag: assert property ( // R16
    tx_ok |=> tx_valid_o && tx_frame_o == $past(tx_sel_frame)
      && tx_frame_o.extended_format_select == $past(ext_fmt_i[tx_obj_i]))
    else $error("transmit tag differs from stored tag");

  a_ext_b1_readback: assert property ( // R5
    s_wr(CIM_ADDR_IDT1) ##1 (s_rd_same(CIM_ADDR_IDT1) && sel_ext)
      |=> sfr_rdata_o == $past(sfr_req_i.wdata, 2))
    else $error("extended tag byte 1 lost bits");

  a_ext_b3_readback: assert property ( // R7
    s_wr(CIM_ADDR_IDT3) ##1 (s_rd_same(CIM_ADDR_IDT3) && sel_ext)
      |=> sfr_rdata_o == $past(sfr_req_i.wdata, 2))
    else $error("extended tag byte 3 lost bits");

  a_std_b1_readback: assert property ( // R1
    s_wr(CIM_ADDR_IDT1) ##1 (s_rd_same(CIM_ADDR_IDT1) && !sel_ext)
      |=> sfr_rdata_o == $past(sfr_req_i.wdata, 2))
    else $error("standard tag byte 1 lost bits");

  a_std_b2_idbits: assert property ( // R2
    s_wr(CIM_ADDR_IDT2) ##1 (s_rd_same(CIM_ADDR_IDT2) && !sel_ext)
      |=> sfr_rdata_o[7:5] == $past(sfr_req_i.wdata[7:5], 2))
    else $error("standard tag byte 2 lost identifier bits");

  a_std_b4_tags: assert property ( // R4
    s_wr(CIM_ADDR_IDT4) ##1 (s_rd_same(CIM_ADDR_IDT4) && !sel_ext)
      |=> sfr_rdata_o[2] == $past(sfr_req_i.wdata[2], 2)
        && sfr_rdata_o[0] == $past(sfr_req_i.wdata[0], 2))
    else $error("standard tag byte 4 lost tag bits");

  a_std_mask_b2_bits: assert property ( // R10
    s_wr(CIM_ADDR_IDM2) ##1 (s_rd_same(CIM_ADDR_IDM2) && !sel_ext)
      |=> sfr_rdata_o[7:5] == $past(sfr_req_i.wdata[7:5], 2))
    else $error("standard mask byte 2 lost mask bits");

  a_masked_bit_miss: assert property ( // R12
    rx_valid_i && |((rx_frame_i.id ^ obj_frame[2].id) & obj_msk[2])
      |=> !rx_hit_o[2])
    else $error("compared identifier bit differs but object 2 hit");

  a_rtr_mask_miss: assert property ( // R12
    rx_valid_i && mask_byte4_i[2][CIM_B4_RTR_POS]
      && rx_frame_i.rtr != obj_frame[2].rtr
      |=> !rx_hit_o[2])
    else $error("compared remote tag differs but object 2 hit");

  a_ide_mask_miss: assert property ( // R15
    rx_valid_i && mask_byte4_i[2][CIM_B4_IDE_POS] && rx_frame_i.extended_format_select != ext_fmt_i[2]
      |=> !rx_hit_o[2])
    else $error("frame of other format hit object 2");

  a_rx_done_pulse: assert property ( // R17
    rx_done_o == $past(rx_valid_i))
    else $error("acceptance done pulse out of step");

  a_rx_hit_holds: assert property ( // R17
    !rx_valid_i |=> $stable(rx_hit_o[2:0]))
    else $error("acceptance result changed without a frame");

  a_tx_refused: assert property ( // R16
    tx_req_i && !tx_ok |=> !tx_valid_o && $stable(tx_frame_o))
    else $error("transmit tag given for no object");

  a_tx_std_layout: assert property ( // R15
    tx_ok && !ext_fmt_i[tx_obj_i]
      |=> tx_frame_o.id[28:11] == 18'h0 && !tx_frame_o.extended_format_select && !tx_frame_o.rb1)
    else $error("standard transmit tag has extended fields");

  a_tx_ext_ide: assert property ( // R15
    tx_ok && ext_fmt_i[tx_obj_i] |=> tx_frame_o.extended_format_select)
    else $error("extended transmit tag lacks format flag");

  a_ext_tx_id: assert property ( // R5 R7
    tx_ok && ext_fmt_i[tx_obj_i] |=> tx_frame_o.id[28:21] == $past(tag_q[tx_obj_i][0])
      && tx_frame_o.id[12:5] == $past(tag_q[tx_obj_i][2]))
    else $error("extended transmit identifier misplaced");

  a_std_tx_id: assert property ( // R1 R2
    tx_ok && !ext_fmt_i[tx_obj_i]
      |=> tx_frame_o.id[10:3] == $past(tag_q[tx_obj_i][0])
        && tx_frame_o.id[2:0] == $past(tag_q[tx_obj_i][1][7:5]))
    else $error("standard transmit identifier misplaced");

  c_rx_hit: cover property (rx_done_o && rx_hit_o != '0);
  c_tx_ext: cover property (tx_valid_o && tx_frame_o.extended_format_select);
  c_std_read: cover property (sfr_hit_o && !$past(sel_ext));
  c_ext_read: cover property (sfr_hit_o && $past(sel_ext));
  c_rx_miss: cover property (rx_done_o && rx_hit_o[2:1] == 2'h0);

endmodule

// [rtl/cim_pkg.sv]
// identifier tag and mask window: constants, field layout and carrier types
// assumes one core clock; cpu sfr port and protocol engine share that clock
//
// Functional notes
// R1: standard format, tag byte 1 at BCh carries identifier bits 10..3 in positions 7..0.
// R2: standard format, tag byte 2 at BDh carries identifier bits 2..0 in 7..5, 4..0 reserved.
// R3: standard format, tag byte 3 at BEh holds no functional bit, all eight reserved.
// R4: standard format, tag byte 4 at BFh has remote tag at bit 2 and rb0 tag at bit 0.
// R5: extended format, tag byte 1 at BCh carries identifier bits 28..21.
// R6: extended format, tag byte 2 at BDh carries identifier bits 20..13.
// R7: extended format, tag byte 3 at BEh carries identifier bits 12..5.
// R8: extended format, tag byte 4 at BFh has id 4..0 in 7..3, remote at 2, rb1 at 1, rb0 at 0.
// R9: standard format, mask byte 1 at C4h holds mask bits for identifier bits 10..3.
// R10: standard format, mask byte 2 at C5h holds mask bits for id 2..0 in 7..5, 4..0 reserved.
// R11: standard format, mask byte 3 at C6h holds no functional bit.
// R12: a mask bit at 0 forces its comparison true, at 1 it enables the comparison.
// R13: software never writes ones to reserved bits and treats their read value as undefined.
// R14: tag and mask bytes have no value after reset until software writes them.
// R15: the per object format flag picks standard (11 bit id) or extended (29 bit id) layout.
// R16: the mask filters received frames only, transmission uses the bare tag.
// R17: a frame matches an object when each compared bit is masked off or equal to the tag.

package cim_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int unsigned CIM_NUM_OBJ = 15;
  localparam int unsigned CIM_OBJ_W   = 4;
  localparam int unsigned CIM_ID_W    = 29;

  // ****************************************
  // sfr offsets
  // ****************************************
  localparam logic [7:0] CIM_ADDR_IDT1 = 8'hBC;
  localparam logic [7:0] CIM_ADDR_IDT2 = 8'hBD;
  localparam logic [7:0] CIM_ADDR_IDT3 = 8'hBE;
  localparam logic [7:0] CIM_ADDR_IDT4 = 8'hBF;
  localparam logic [7:0] CIM_ADDR_IDM1 = 8'hC4;
  localparam logic [7:0] CIM_ADDR_IDM2 = 8'hC5;
  localparam logic [7:0] CIM_ADDR_IDM3 = 8'hC6;

  // ****************************************
  // field positions and read masks
  // ****************************************
  localparam int unsigned CIM_B4_RTR_POS   = 2;
  localparam int unsigned CIM_B4_RB1_POS   = 1;
  localparam int unsigned CIM_B4_RB0_POS   = 0;
  localparam int unsigned CIM_B4_IDE_POS   = 0;
  localparam int unsigned CIM_B2_STD_LSB   = 5;
  localparam int unsigned CIM_B4_EXT_LSB   = 3;
  localparam logic [7:0]  CIM_STD_B2_RMASK = 8'hE0;
  localparam logic [7:0]  CIM_STD_B3_RMASK = 8'h00;
  localparam logic [7:0]  CIM_STD_B4_RMASK = 8'h05;
  localparam logic [7:0]  CIM_FULL_RMASK   = 8'hFF;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] CIM_RDATA_RST = 8'h00;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cim_sfr_req_t;

  typedef struct packed {
    logic [CIM_ID_W-1:0] id;
    logic                rtr;
    logic                extended_format_select;
    logic                rb1;
    logic                rb0;
  } cim_frame_t;

endpackage

// [test/cim_id_filter_tb.sv]
// self-checking bench for the identifier tag and mask window
// assumes cim_pkg compiled first; the bench drives every block port itself
`timescale 1ns/1ps

module tb
  import cim_pkg::*;
();
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic                              ref_clk_i = 1'b0;
  logic                              reset_n_i = 1'b0;
  cim_sfr_req_t                      sfr_req   = '0;
  logic [CIM_OBJ_W-1:0]              obj_sel   = '0;
  logic [7:0]                        sfr_rdata;
  logic                              sfr_hit;
  logic [CIM_NUM_OBJ-1:0]            ext_fmt   = 15'h0004;
  logic [CIM_NUM_OBJ-1:0][7:0]       msk4      = '0;
  logic                              rx_valid  = 1'b0;
  cim_frame_t                        rx_frame  = '0;
  logic [CIM_NUM_OBJ-1:0]            rx_hit;
  logic                              rx_done;
  logic                              tx_req    = 1'b0;
  logic [CIM_OBJ_W-1:0]              tx_obj    = '0;
  cim_frame_t                        tx_frame;
  logic                              tx_valid;
  int                                err_count = 0;
  int                                tests_run = 0;
  localparam logic [28:0] EID = {8'hA5, 8'h3C, 8'h96, 5'b11010};
  localparam logic [28:0] SID = {18'h0, 8'h6B, 3'b101};

  always #2.5 ref_clk_i = ~ref_clk_i;

  cim_id_filter DUT (
    .ref_clk_i    (ref_clk_i),
    .reset_n_i    (reset_n_i),
    .sfr_req_i    (sfr_req),
    .obj_sel_i    (obj_sel),
    .sfr_rdata_o  (sfr_rdata),
    .sfr_hit_o    (sfr_hit),
    .ext_fmt_i    (ext_fmt),
    .mask_byte4_i (msk4),
    .rx_valid_i   (rx_valid),
    .rx_frame_i   (rx_frame),
    .rx_hit_o     (rx_hit),
    .rx_done_o    (rx_done),
    .tx_req_i     (tx_req),
    .tx_obj_i     (tx_obj),
    .tx_frame_o   (tx_frame),
    .tx_valid_o   (tx_valid)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  function automatic cim_frame_t fr(logic [28:0] id, logic rtr, logic extended_format_select, logic rb1, logic rb0);
    fr = '{id: id, rtr: rtr, extended_format_select: extended_format_select, rb1: rb1, rb0: rb0};
  endfunction

  // one sfr cycle, strobes left up for a back to back follower
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic idle;
    sfr_req.wr = 1'b0;
    sfr_req.rd = 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask

  // write each byte and read it straight back, comparing defined bits only
  task automatic regs(input logic [3:0] obj, input logic [6:0][7:0] v, input logic [6:0][7:0] m);
    logic [6:0][7:0] ad;
    ad = {8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hC4, 8'hC5, 8'hC6};
    obj_sel = obj;
    for (int i = 6; i >= 0; i--) begin
      acc(1'b1, 1'b0, ad[i], v[i]);
      acc(1'b0, 1'b1, ad[i], 8'h00);
      chk(sfr_hit === 1'b1 && (sfr_rdata & m[i]) === (v[i] & m[i]), "byte read back");
    end
    idle();
  endtask

  task automatic txq(input logic [3:0] obj, input logic ev, input cim_frame_t ef);
    tx_obj = obj;
    tx_req = 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk(tx_valid === ev && tx_frame === ef, "tag frame");
    tx_req = 1'b0;
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic rxq(input cim_frame_t f, input logic [1:0] eh);
    rx_frame = f;
    rx_valid = 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk(rx_done === 1'b1 && rx_hit[2:0] === {eh, 1'b1}, "acceptance result");
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk(sfr_rdata === 8'h00 && sfr_hit === 1'b0 && rx_done === 1'b0, "reset sfr outputs");
    chk(rx_hit === '0 && tx_valid === 1'b0 && tx_frame === '0, "reset filter outputs");
  endtask

  task automatic t_regs;
    regs(4'h0, {8'h6B, 8'hA0, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00},
         {8'hFF, 8'hE0, 8'h00, 8'h05, 8'hFF, 8'hE0, 8'h00});
    regs(4'd2, {8'hA5, 8'h3C, 8'h96, 8'hD6, 8'hFF, 8'hF0, 8'h00}, {7{8'hFF}});
    regs(4'd1, {8'h6B, 8'hA0, 8'h00, 8'h04, 8'hF0, 8'hE0, 8'h00},
         {8'hFF, 8'hE0, 8'h00, 8'h05, 8'hFF, 8'hE0, 8'h00});
  endtask

  task automatic t_refuse;
    obj_sel = 4'd15;
    acc(1'b1, 1'b0, 8'hBC, 8'h00);
    acc(1'b0, 1'b1, 8'hBC, 8'h00);
    chk(sfr_hit === 1'b0 && sfr_rdata === 8'h00, "read without object");
    obj_sel = 4'd2;
    acc(1'b0, 1'b1, 8'hBC, 8'h00);
    chk(sfr_hit === 1'b1 && sfr_rdata === 8'hA5, "write without object");
    acc(1'b0, 1'b1, 8'hC7, 8'h00);
    chk(sfr_hit === 1'b0 && sfr_rdata === 8'hA5, "unmapped read");
    idle();
  endtask

  task automatic t_tx;
    txq(4'd2, 1'b1, fr(EID, 1'b1, 1'b1, 1'b1, 1'b0));
    txq(4'd1, 1'b1, fr(SID, 1'b1, 1'b0, 1'b0, 1'b0));
    txq(4'd15, 1'b0, fr(SID, 1'b1, 1'b0, 1'b0, 1'b0));
  endtask

  task automatic t_rx;
    msk4[2] = 8'hFD;
    msk4[1] = 8'h05;
    rxq(fr(EID, 1'b1, 1'b1, 1'b0, 1'b0), 2'b10);
    rxq(fr(EID ^ 29'h0001000, 1'b1, 1'b1, 1'b0, 1'b0), 2'b10);
    rxq(fr(EID ^ 29'h0100000, 1'b1, 1'b1, 1'b0, 1'b0), 2'b00);
    rxq(fr(EID, 1'b0, 1'b1, 1'b0, 1'b0), 2'b00);
    rxq(fr(SID, 1'b1, 1'b0, 1'b0, 1'b0), 2'b01);
    rxq(fr(SID ^ 29'h0000010, 1'b1, 1'b0, 1'b0, 1'b0), 2'b01);
    rxq(fr(SID ^ 29'h0000200, 1'b1, 1'b0, 1'b0, 1'b0), 2'b00);
    rxq(fr(EID, 1'b1, 1'b0, 1'b0, 1'b0), 2'b00);
    rx_valid = 1'b0;
  endtask

  task automatic t_fmt;
    ext_fmt[2] = 1'b0;
    acc(1'b0, 1'b1, 8'hBF, 8'h00);
    chk(sfr_hit === 1'b1 && (sfr_rdata & CIM_STD_B4_RMASK) === 8'h04, "format switch");
    idle();
    txq(4'd2, 1'b1, fr({18'h0, 8'hA5, 3'b001}, 1'b1, 1'b0, 1'b0, 1'b0));
  endtask

  initial begin
    repeat (12) @(posedge ref_clk_i);
    #1;
    t_reset();
    reset_n_i = 1'b1;
    t_regs();
    t_refuse();
    t_tx();
    t_rx();
    t_fmt();
    conclude();
  end

  initial begin
    #20000;
    err_count++;
    $display("watchdog expired at %0t", $time);
    conclude();
  end
endmodule
